// ---- verilog/cmp_pkg.sv ----
// Purpose: Shared constants and types of the calibration store
// Assumes: 32-bit classic Wishbone, word index = byte address / 4
// Notes:   Nonvolatile array contents survive srst; mtp_blank erases
package cmp_pkg;
	// Word indices of the system registers
	localparam logic [6:0] IDX_CTRL   = 7'h02;  // Slot count, rate select
	localparam logic [6:0] IDX_TCAL   = 7'h04;  // Temperature gain/offset
	localparam logic [6:0] IDX_TSEL   = 7'h09;  // Temperature select
	localparam logic [6:0] IDX_COEF0  = 7'h2E;  // First rate coefficient
	localparam logic [6:0] IDX_COEFN  = 7'h33;  // Last rate coefficient
	localparam logic [6:0] IDX_CMD    = 7'h40;  // Program command
	localparam logic [6:0] IDX_STAT   = 7'h41;  // Program status
	localparam int         NUM_COEF   = 6;      // Coefficient words
	localparam int         NUM_SLOT   = 8;      // Nonvolatile slots
	// Field positions
	localparam int SLOT_LO   = 8;               // Slot count low bit
	localparam int SLOT_HI   = 15;              // Slot count high bit
	localparam int RSEL_BIT  = 27;              // Rate output select
	localparam int TSEL_BIT  = 2;               // Temperature select
	localparam int GAIN_LO   = 2;               // Temp gain low bit
	localparam int GAIN_HI   = 13;              // Temp gain high bit
	localparam int OFFS_LO   = 16;              // Temp offset low bit
	localparam int OFFS_HI   = 27;              // Temp offset high bit
	localparam int GAIN_FRAC = 9;               // Gain fraction bits
	localparam int STAT_BUSY = 0;               // Status busy bit
	localparam int STAT_REF  = 1;               // Status refused bit
	// Reset and factory values
	localparam logic [7:0]  SLOT_FULL  = 8'hFF; // No slot left
	localparam logic [7:0]  SLOT_ONCE  = 8'h01; // Programmed once
	localparam logic [11:0] GAIN_DEF   = 12'h800;
	localparam logic [31:0] CTRL_DEF   = 32'h0000_0100;
	localparam logic [31:0] TCAL_DEF   = 32'h0000_2000;
	localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
	// Programming time of one nonvolatile word
	localparam int PROG_TIME_NS = 2000;
	localparam int CLK_NS       = 4;
	localparam int PROG_CYC     = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [9:0] PROG_LAST = 10'(PROG_CYC - 1);
	// Control states
	typedef enum logic [2:0]
	{
		ST_LOAD = 3'b001,
		ST_IDLE = 3'b010,
		ST_PROG = 3'b100
	} cmp_state_type;
	// Active rate compensation coefficients
	typedef struct packed
	{
		logic [15:0] scale_quadratic_term;
		logic [15:0] bias_quadratic_term;
		logic [29:0] bias_linear_term;
		logic [29:0] bias_constant_term;
		logic [29:0] scale_linear_term;
		logic [29:0] scale_constant_term;
		logic [19:0] mid_temperature_point;
	} cmp_coef_type;
endpackage

// ---- verilog/cmp_calib_store.sv ----
// Purpose: System registers and nonvolatile store for calibration
// Assumes: Wishbone master keeps cyc/stb until ack; one clock mclk
// Notes:   Active coefficient slot follows the stored count after srst
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
// Contract
// - At most seven further coefficient programmings
// - Slot count is thermometer code, ones added
// - New coefficients need updated slot count
// - New coefficients take effect after reset
// - Rate select one gives raw rate
// - Calibrated temperature equals gain times raw plus offset
// - Slot count at bits 15:8, address 0x02
// - Rate select at bit 27, address 0x02
// - Temperature select at address 0x09
// - Gain 13:2 default 0x800, offset 27:16
module cmp_calib_store
(
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  mtp_blank,
	input  wire logic [8:0]            adr_i,
	input  wire logic [31:0]           dat_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic                  we_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	input  wire logic [23:0]           raw_rate,
	input  wire logic [23:0]           comp_rate,
	input  wire logic [15:0]           raw_temp,
	output logic      [23:0]           rate_out,
	output logic      [15:0]           temp_out,
	output cmp_pkg::cmp_coef_type      coef_out
);
	import cmp_pkg::*;
	// Ones in a thermometer word give the programmed count
	function automatic logic [3:0] ones(input logic [7:0] v);
		return 4'($countones(v));
	endfunction
	// Merge write data into a word by byte lane
	function automatic logic [31:0] lanes(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = wr[8*b +: 8];
		return r;
	endfunction
	// Pin synchroniser for the erase strap
	logic        blank_s1;            // First stage, read by stage two only
	logic        blank_s2;            // Safe level
	// System registers
	logic [31:0] r_ctrl, next_r_ctrl; // Slot count and rate select
	logic [31:0] r_tcal, next_r_tcal; // Temperature gain and offset
	logic [31:0] r_tsel, next_r_tsel; // Temperature select word
	logic [31:0] r_coef [NUM_COEF], next_r_coef [NUM_COEF]; // Rate coefs
	// Nonvolatile store
	logic [31:0] m_ctrl;              // Stored slot count word
	logic [31:0] m_tcal;              // Stored temperature calibration
	logic [31:0] m_tsel;              // Stored temperature select
	logic [31:0] m_coef [NUM_SLOT][NUM_COEF];
	// Control
	cmp_state_type state, next_state;
	logic [9:0]  timer, next_timer;   // Programming time counter
	logic [6:0]  pidx, next_pidx;     // Word being programmed
	logic        refused, next_refused; // Sticky refusal flag
	logic        ack, next_ack;       // Bus answer
	logic [31:0] rdat, next_rdat;     // Bus read data
	logic        mtp_we;              // Store the word now
	logic [2:0]  wslot;               // Slot taking a new coefficient
	logic [2:0]  aslot;               // Slot read at load
	logic [6:0]  widx;                // Word index of bus access
	logic        wr_now;              // Write takes effect this edge
	logic [7:0]  m_slot;              // Stored slot count
	logic [7:0]  r_slot;              // Slot count in system register
	logic        ok_prog;             // Command may start
	logic [2:0]  ck;                  // Coefficient index of pidx
	assign widx   = adr_i[8:2];
	assign wr_now = cyc_i & stb_i & we_i & ack;
	assign m_slot = m_ctrl[SLOT_HI:SLOT_LO];
	assign r_slot = r_ctrl[SLOT_HI:SLOT_LO];
	// Next free slot; the active slot is the last programmed one
	assign wslot  = 3'(ones(m_slot));
	assign aslot  = (m_slot == 8'h00) ? 3'h0
		: 3'(ones(m_slot) - 4'h1);
	assign ck     = 3'(pidx - IDX_COEF0);
	assign ack_o  = ack;
	assign dat_o  = rdat;
	// Erase strap passes two flip-flops
	always_ff @(posedge mclk)
	begin
		blank_s1 <= mtp_blank;
		blank_s2 <= blank_s1;
	end
	// Next values of bus, registers and sequencer
	always_comb
	begin
		next_state   = state;
		next_timer   = timer;
		next_pidx    = pidx;
		next_refused = refused;
		next_r_ctrl  = r_ctrl;
		next_r_tcal  = r_tcal;
		next_r_tsel  = r_tsel;
		next_r_coef  = r_coef;
		next_ack     = cyc_i & stb_i & ~ack;
		next_rdat    = WORD_ZERO;
		mtp_we       = 1'b0;
		ok_prog      = 1'b0;
		// Read data for an unmapped word stays zero
		if (cyc_i & stb_i & ~ack)
		begin
			if (widx == IDX_CTRL)
				next_rdat = r_ctrl;
			else if (widx == IDX_TCAL)
				next_rdat = r_tcal;
			else if (widx == IDX_TSEL)
				next_rdat = r_tsel;
			else if (widx >= IDX_COEF0 && widx <= IDX_COEFN)
				next_rdat = r_coef[3'(widx - IDX_COEF0)];
			else if (widx == IDX_CMD)
				next_rdat = {25'h0, pidx};
			else if (widx == IDX_STAT)
			begin
				next_rdat[STAT_BUSY] = (state != ST_IDLE);
				next_rdat[STAT_REF]  = refused;
			end
		end
		// Writes land on the acknowledging edge
		if (wr_now)
		begin
			if (widx == IDX_CTRL)
				next_r_ctrl = lanes(r_ctrl, dat_i, sel_i);
			else if (widx == IDX_TCAL)
				next_r_tcal = lanes(r_tcal, dat_i, sel_i);
			else if (widx == IDX_TSEL)
				next_r_tsel = lanes(r_tsel, dat_i, sel_i);
			else if (widx >= IDX_COEF0 && widx <= IDX_COEFN)
				next_r_coef[3'(widx - IDX_COEF0)] =
					lanes(r_coef[3'(widx - IDX_COEF0)], dat_i, sel_i);
			else if (widx == IDX_STAT && sel_i[0] && dat_i[STAT_REF])
				next_refused = 1'b0;
		end
		// Sequencer
		case (state)
			ST_LOAD:
			begin
				// Settings come back from the store after reset
				next_r_ctrl = m_ctrl;
				next_r_tcal = m_tcal;
				next_r_tsel = m_tsel;
				for (int k = 0; k < NUM_COEF; k++)
					next_r_coef[k] = m_coef[aslot][k];
				next_state = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (wr_now && widx == IDX_CMD && sel_i[0])
				begin
					// Coefficients need a free slot
					if (dat_i[6:0] >= IDX_COEF0
						&& dat_i[6:0] <= IDX_COEFN)
						ok_prog = (m_slot != SLOT_FULL);
					// Slot count stays or steps by one thermometer bit
					else if (dat_i[6:0] == IDX_CTRL)
						ok_prog = (m_slot != SLOT_FULL)
							&& (r_slot == m_slot
							|| r_slot == {m_slot[6:0], 1'b1});
					else
						ok_prog = (dat_i[6:0] == IDX_TCAL)
							|| (dat_i[6:0] == IDX_TSEL);
					if (ok_prog)
					begin
						next_pidx  = dat_i[6:0];
						next_timer = 10'h000;
						next_state = ST_PROG;
					end
					else
						next_refused = 1'b1;
				end
			end
			ST_PROG:
			begin
				// Further commands while busy are refused; set wins
				if (wr_now && widx == IDX_CMD && sel_i[0])
					next_refused = 1'b1;
				next_timer = timer + 10'h001;
				if (timer == PROG_LAST)
				begin
					mtp_we     = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default:
				next_state = ST_LOAD;
		endcase
	end
	// Register the sequencer and system registers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state   <= ST_LOAD;
			timer   <= 10'h000;
			pidx    <= 7'h00;
			refused <= 1'b0;
			ack     <= 1'b0;
			rdat    <= WORD_ZERO;
			r_ctrl  <= CTRL_DEF;
			r_tcal  <= TCAL_DEF;
			r_tsel  <= WORD_ZERO;
			r_coef  <= '{default: WORD_ZERO};
		end
		else
		begin
			state   <= next_state;
			timer   <= next_timer;
			pidx    <= next_pidx;
			refused <= next_refused;
			ack     <= next_ack;
			rdat    <= next_rdat;
			r_ctrl  <= next_r_ctrl;
			r_tcal  <= next_r_tcal;
			r_tsel  <= next_r_tsel;
			r_coef  <= next_r_coef;
		end
	end
	// Nonvolatile store: untouched by srst, erased by the strap
	always_ff @(posedge mclk)
	begin
		if (blank_s2)
		begin
			m_ctrl <= CTRL_DEF;
			m_tcal <= TCAL_DEF;
			m_tsel <= WORD_ZERO;
			m_coef <= '{default: '{default: WORD_ZERO}};
		end
		else if (mtp_we)
		begin
			if (pidx == IDX_CTRL)
				m_ctrl <= r_ctrl;
			else if (pidx == IDX_TCAL)
				m_tcal <= r_tcal;
			else if (pidx == IDX_TSEL)
				m_tsel <= r_tsel;
			else
				m_coef[wslot][ck] <= r_coef[ck];
		end
	end
	// Output selection and temperature calibration
	logic signed [28:0] tprod;        // Gain times raw temperature
	logic        [15:0] next_temp;    // Calibrated or raw temperature
	always_comb
	begin
		tprod = $signed({1'b0, r_tcal[GAIN_HI:GAIN_LO]})
			* $signed(raw_temp);
		next_temp = raw_temp;
		if (r_tsel[TSEL_BIT])
			next_temp = 16'(tprod >>> GAIN_FRAC)
				+ {4'h0, r_tcal[OFFS_HI:OFFS_LO]};
	end
	// Data outputs come from flip-flops
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rate_out <= 24'h000000;
			temp_out <= 16'h0000;
			coef_out <= '0;
		end
		else
		begin
			rate_out <= r_ctrl[RSEL_BIT] ? raw_rate : comp_rate;
			temp_out <= next_temp;
			coef_out <= {r_coef[0], r_coef[1][29:0], r_coef[2][29:0],
				r_coef[3][29:0], r_coef[4][29:0], r_coef[5][19:0]};
		end
	end
	AST_RATE_RAW: assert property (@(posedge mclk) disable iff (srst)
		r_ctrl[RSEL_BIT] |=> rate_out == $past(raw_rate))
		else $error("raw rate not passed");
	AST_RATE_CAL: assert property (@(posedge mclk) disable iff (srst)
		!r_ctrl[RSEL_BIT] |=> rate_out == $past(comp_rate))
		else $error("compensated rate not passed");
	AST_TEMP_CAL: assert property (@(posedge mclk) disable iff (srst)
		r_tsel[TSEL_BIT] |=> temp_out == 16'($signed(
		29'($past(r_tcal[GAIN_HI:GAIN_LO])) * 29'($signed($past(raw_temp))))
		>>> GAIN_FRAC) + {4'h0, $past(r_tcal[OFFS_HI:OFFS_LO])})
		else $error("temperature output wrong");
	AST_FULL_REFUSE: assert property (@(posedge mclk) disable iff (srst)
		state == ST_IDLE && m_slot == SLOT_FULL && wr_now
		&& widx == IDX_CMD && sel_i[0] && dat_i[6:0] == IDX_COEF0
		|=> refused && state == ST_IDLE)
		else $error("program accepted with no slot");
	AST_THERMO: assert property (@(posedge mclk) disable iff (srst)
		mtp_we && pidx == IDX_CTRL && !blank_s2
		|=> m_slot == $past(m_slot) || m_slot == {$past(m_slot[6:0]), 1'b1})
		else $error("slot count not thermometer step");
	AST_LOAD_SLOT: assert property (@(posedge mclk) disable iff (srst)
		state == ST_LOAD && !blank_s2 |=> r_coef[0] == $past(m_coef[aslot][0]))
		else $error("load did not use active slot");
	AST_NO_LIVE: assert property (@(posedge mclk) disable iff (srst)
		mtp_we && pidx == IDX_COEF0 ##1 !wr_now [*2]
		|-> $stable(r_coef[0]))
		else $error("coefficient changed without reset");
	AST_PROG_TIME: assert property (@(posedge mclk) disable iff (srst)
		$rose(state == ST_PROG) |-> ##[499:499] mtp_we)
		else $error("programming time wrong");
	AST_MAP_CTRL: assert property (@(posedge mclk) disable iff (srst)
		cyc_i && stb_i && !ack && !we_i && widx == IDX_CTRL
		|=> ack && dat_o[SLOT_HI:SLOT_LO] == $past(r_slot))
		else $error("slot count read wrong");
	AST_GAIN_DEF: assert property (@(posedge mclk)
		$fell(srst) |-> r_tcal[GAIN_HI:GAIN_LO] == GAIN_DEF)
		else $error("gain default wrong");
	AST_ACK_ONE: assert property (@(posedge mclk) disable iff (srst)
		ack |=> !ack)
		else $error("ack longer than one cycle");
	CV_PROG: cover property (@(posedge mclk) mtp_we && pidx == IDX_CTRL);
	CV_COEF: cover property (@(posedge mclk) mtp_we && pidx == IDX_COEF0);
	CV_REFUSE: cover property (@(posedge mclk) $rose(refused));
	CV_TEMP: cover property (@(posedge mclk)
		r_tsel[TSEL_BIT] && r_ctrl[RSEL_BIT]);
endmodule // cmp_calib_store

// ---- sim/cmp_host_model.sv ----
// Purpose: Host side, classic Wishbone master for the store
// Assumes: Bench calls the tasks, one request at a time
// Notes:   hang marks an answer or a program that never ended
`timescale 1ns/10ps
module cmp_host_model
(
	input  wire logic        mclk,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	output logic      [8:0]  adr_i,
	output logic      [31:0] dat_i,
	output logic      [3:0]  sel_i,
	output logic             we_i,
	output logic             cyc_i,
	output logic             stb_i
);
	import cmp_pkg::*;
	logic        hang = 1'b0; // No answer within bound
	logic [31:0] rd   = '0;   // Read data of last transfer
	initial
		{adr_i, dat_i, sel_i, we_i, cyc_i, stb_i} = '0;
	// Request held until ack is sampled high, then released
	task automatic xfer(input logic w, input logic [6:0] idx,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		adr_i <= {idx, 2'b00};
		dat_i <= d;
		sel_i <= 4'hF;
		we_i  <= w;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1)
			hang = 1'b1;
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask
	// Field update that keeps every other bit
	task automatic rmw(input logic [6:0] idx, input logic [31:0] m,
		input logic [31:0] v);
		xfer(1'b0, idx, WORD_ZERO);
		xfer(1'b1, idx, (rd & ~m) | (v & m));
	endtask
	// Program one word, wait until busy falls
	task automatic prog(input logic [6:0] idx);
		int n;
		n = 0;
		xfer(1'b1, IDX_CMD, {25'h0, idx});
		do
		begin
			xfer(1'b0, IDX_STAT, WORD_ZERO);
			n++;
		end
		while (rd[STAT_BUSY] !== 1'b0 && n < 400);
		if (rd[STAT_BUSY] !== 1'b0)
			hang = 1'b1;
	endtask
endmodule // cmp_host_model

// ---- sim/calibration_mtp_programming_test.sv ----
// Purpose: Self-checking bench of the calibration store
// Assumes: Host model drives the bus; seed fixed
// Notes:   A cycle watchdog bounds the whole run
`timescale 1ns/10ps
module calibration_mtp_programming_test;
	import cmp_pkg::*;
	logic         mclk      = 1'b0; // 250 MHz clock
	logic         srst      = 1'b1; // Synchronous reset
	logic         mtp_blank = 1'b1; // Store erase
	logic  [23:0] raw_rate  = '0;   // Uncompensated rate
	logic  [23:0] comp_rate = '0;   // Compensated rate
	logic  [15:0] raw_temp  = '0;   // Raw temperature
	logic  [8:0]  adr_i;            // Bus address
	logic  [31:0] dat_i;            // Bus write data
	logic  [3:0]  sel_i;            // Byte lanes
	logic         we_i, cyc_i, stb_i;
	logic  [31:0] dat_o;            // Bus read data
	logic         ack_o;            // Bus answer
	logic  [23:0] rate_out;         // Selected rate
	logic  [15:0] temp_out;         // Temperature out
	cmp_coef_type coef_out;         // Active coefficients
	int           err_total = 0;    // Mismatches
	int           checked   = 0;    // Comparisons
	int           ord [NUM_COEF] = '{0, 3, 4, 1, 2, 5}; // Program order
	cmp_calib_store cmp_calib_store_i
	(
		.mclk(mclk), .srst(srst), .mtp_blank(mtp_blank),
		.adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.raw_rate(raw_rate), .comp_rate(comp_rate),
		.raw_temp(raw_temp), .rate_out(rate_out),
		.temp_out(temp_out), .coef_out(coef_out)
	);
	cmp_host_model cmp_host_model_i
	(
		.mclk(mclk), .dat_o(dat_o), .ack_o(ack_o), .adr_i(adr_i),
		.dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
		.stb_i(stb_i)
	);
	// Free running clock
	initial
		forever #2 mclk = ~mclk;
	// Mismatch reporting
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic print_verdict();
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Short reset; bus starts three cycles after release
	task automatic do_reset();
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// Gain times signed raw, shifted by nine, plus offset
	function automatic logic [15:0] temp_exp(input logic [11:0] g,
		input logic [11:0] o, input logic [15:0] r);
		logic signed [31:0] p;
		p = $signed({1'b0, g}) * $signed(r);
		p = p >>> GAIN_FRAC;
		return 16'(p + 32'(o));
	endfunction
	// Coefficient words mapped onto the active set
	function automatic cmp_coef_type coef_exp(input logic [31:0] v [NUM_COEF]);
		cmp_coef_type e;
		e.scale_quadratic_term  = v[0][31:16];
		e.bias_quadratic_term   = v[0][15:0];
		e.bias_linear_term      = v[1][29:0];
		e.bias_constant_term    = v[2][29:0];
		e.scale_linear_term     = v[3][29:0];
		e.scale_constant_term   = v[4][29:0];
		e.mid_temperature_point = v[5][19:0];
		return e;
	endfunction
	// Watchdog on cycles and on host hangs
	initial
	begin
		for (int c = 0; c < 90000 && cmp_host_model_i.hang !== 1'b1; c++)
			@(posedge mclk);
		err_total++;
		print_verdict();
	end
	// Main sequence
	initial
	begin
		logic        sel;
		logic [11:0] g, o;
		logic [31:0] w [NUM_COEF];
		void'($urandom(58));
		repeat (10) @(posedge mclk);
		mtp_blank <= 1'b0;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
		cmp_host_model_i.xfer(1'b0, IDX_CTRL, WORD_ZERO);
		check(cmp_host_model_i.rd, CTRL_DEF);
		cmp_host_model_i.xfer(1'b0, IDX_TCAL, WORD_ZERO);
		check(cmp_host_model_i.rd, TCAL_DEF);
		cmp_host_model_i.xfer(1'b0, IDX_TSEL, WORD_ZERO);
		check(cmp_host_model_i.rd, WORD_ZERO);
		// Rate select both ways, random data
		for (int i = 0; i < 4; i++)
		begin
			sel = i[0];
			cmp_host_model_i.rmw(IDX_CTRL, 32'h0800_0000, 32'(sel) << RSEL_BIT);
			raw_rate <= 24'($urandom);
			comp_rate <= 24'($urandom);
			repeat (3) @(posedge mclk);
			check(rate_out, sel ? raw_rate : comp_rate);
		end
		// Select cleared, raw at two points, then calibrated, corner first
		cmp_host_model_i.rmw(IDX_TSEL, 32'h4, WORD_ZERO);
		for (int i = 0; i < 2; i++)
		begin
			raw_temp <= 16'($urandom);
			repeat (3) @(posedge mclk);
			check(temp_out, raw_temp);
		end
		for (int i = 0; i < 4; i++)
		begin
			g = (i == 0) ? 12'hFFF : 12'($urandom);
			o = 12'($urandom);
			cmp_host_model_i.rmw(IDX_TCAL, 32'h0FFF_3FFC,
				{4'h0, o, 2'h0, g, 2'h0});
			cmp_host_model_i.rmw(IDX_TSEL, 32'h4, 32'h4);
			raw_temp <= (i == 0) ? 16'h8000 : 16'($urandom);
			repeat (3) @(posedge mclk);
			check(temp_out, temp_exp(g, o, raw_temp));
		end
		// Commit gain, offset and select; they return after reset
		cmp_host_model_i.prog(IDX_TCAL);
		cmp_host_model_i.prog(IDX_TSEL);
		check(cmp_host_model_i.rd[STAT_REF], 1'b0);
		// Coefficients programmed in ord order, count not yet updated
		cmp_host_model_i.xfer(1'b0, IDX_CTRL, WORD_ZERO);
		check(cmp_host_model_i.rd[SLOT_HI:SLOT_LO], SLOT_ONCE);
		foreach (w[k])
			w[k] = $urandom;
		for (int k = 0; k < NUM_COEF; k++)
		begin
			cmp_host_model_i.xfer(1'b1, 7'(IDX_COEF0 + ord[k]), w[ord[k]]);
			cmp_host_model_i.prog(7'(IDX_COEF0 + ord[k]));
		end
		do_reset();
		check(coef_out, '0);
		check(temp_out, temp_exp(g, o, raw_temp));
		cmp_host_model_i.rmw(IDX_CTRL, 32'hFF00, 32'h0300);
		cmp_host_model_i.prog(IDX_CTRL);
		do_reset();
		check(coef_out, coef_exp(w));
		// Count that skips a step is refused
		cmp_host_model_i.rmw(IDX_CTRL, 32'hFF00, 32'h0F00);
		cmp_host_model_i.prog(IDX_CTRL);
		check(cmp_host_model_i.rd[STAT_REF], 1'b1);
		cmp_host_model_i.xfer(1'b1, IDX_STAT, 32'h0000_0002);
		// Use every remaining slot, then expect refusal
		for (int s = 2; s < NUM_SLOT; s++)
		begin
			cmp_host_model_i.rmw(IDX_CTRL, 32'hFF00,
				32'((1 << (s + 1)) - 1) << SLOT_LO);
			cmp_host_model_i.prog(IDX_CTRL);
			check(cmp_host_model_i.rd[STAT_REF], 1'b0);
		end
		cmp_host_model_i.prog(IDX_COEF0);
		check(cmp_host_model_i.rd[STAT_REF], 1'b1);
		do_reset();
		cmp_host_model_i.xfer(1'b0, IDX_CTRL, WORD_ZERO);
		check(cmp_host_model_i.rd[SLOT_HI:SLOT_LO], SLOT_FULL);
		print_verdict();
	end
endmodule // calibration_mtp_programming_test
